// ===== hdl/lcb_bus_slave.sv
// Bus-side transaction control of the look-aside cache
`timescale 1ns/1ps
module lcb_bus_slave import lcb_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Strap
	input wire logic streaming_fast_mode,
	// Processor bus
	input wire logic ts,
	input wire lcb_req_t req,
	input wire logic proc_data_grant,
	input wire logic proc_bus_request,
	input wire logic artry_in,
	input wire logic ext_ta,
	input wire logic copyback_done,
	output lcb_bus_t bus_o,
	output lcb_evt_t evt_o,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	logic en_ff, nxt_en, fast_ff, nxt_fast;
	logic pend_ff, nxt_pend, pend_rd_ff, nxt_pend_rd, pend_burst_ff, nxt_pend_burst;
	logic pend_ack_ff, nxt_pend_ack, act_rd_ff, nxt_act_rd, gap_ff, nxt_gap;
	logic [1:0] ta_left_ff, nxt_ta_left, rt_cnt_ff, nxt_rt_cnt;
	logic fgn_ff, nxt_fgn, fgn_fill_ff, nxt_fgn_fill;
	logic [2:0] fgn_left_ff, nxt_fgn_left;
	lcb_rt_t rt_ff, nxt_rt;
	lcb_bus_t bus_ff, nxt_bus;
	lcb_evt_t evt_ff, nxt_evt;
	lcb_stat_t stat;
	logic [31:0] rdata_ff, nxt_rdata;
	logic claim_ok, retry_new, inval_new, fill_new, fgn_new, fgn_done, foreign_rt;
	logic cur_v, cur_rd, cur_burst, cur_ack, ta_last, last_next, stream, aack_go, start_go;

	assign bus_o = bus_ff;
	assign evt_o = evt_ff;
	assign reg_rdata = rdata_ff;
	// Retry seen on the wire but not driven by this block
	assign foreign_rt = artry_in & ~bus_ff.artry;

	always_comb
	begin
		claim_ok = en_ff & ts & ~req.snoop & req.hit & ~req.inh & (req.rd | ~req.wt) & ~pend_ff;
		retry_new = en_ff & ts & req.hit & (rt_ff == RT_IDLE) &
			(req.snoop ? req.dirty : (req.rd ? (req.inh & req.dirty) : (~req.burst & (req.inh | req.wt))));
		inval_new = en_ff & ts & ~req.snoop & req.rd & req.inh & req.hit & ~req.dirty;
		fill_new = en_ff & ts & ~req.snoop & req.rd & ~req.hit & req.burst & ~req.inh;
		fgn_done = fgn_ff & ext_ta & (fgn_left_ff == FGN_SINGLE);
		fgn_new = ts & ~claim_ok & ~retry_new & (~fgn_ff | fgn_done);
		// Transfer start decisions are made in the start cycle itself
		cur_v = pend_ff | claim_ok;
		cur_rd = pend_ff ? pend_rd_ff : req.rd;
		cur_burst = pend_ff ? pend_burst_ff : req.burst;
		cur_ack = pend_ff & pend_ack_ff;
		ta_last = bus_ff.ta & (ta_left_ff == SINGLE_LEFT);
		last_next = bus_ff.ta & (ta_left_ff == LAST_BUT_ONE);
		// stream only behind own read hit, same device
		stream = fast_ff & ta_last & act_rd_ff & cur_rd & ~fgn_ff;
		aack_go = cur_v & ~cur_ack & ~fgn_ff & (~bus_ff.ta | last_next);
		// Tenure ending at this edge still shows ta or fgn, so at least one idle cycle follows unless a read hit streams
		// start on qualified grant
		start_go = cur_v & proc_data_grant & ~artry_in & (cur_ack | aack_go) &
			((~bus_ff.ta & ~fgn_ff) | stream);

		nxt_bus = bus_ff;
		nxt_evt = '0;
		nxt_bus.claim = claim_ok;
		nxt_bus.aack = aack_go;
		if (start_go)
		begin
			nxt_bus.ta = 1'b1;
			nxt_ta_left = cur_burst ? BURST_LEFT : SINGLE_LEFT;
			nxt_act_rd = cur_rd;
		end
		else
		begin
			nxt_bus.ta = bus_ff.ta & ~ta_last;
			nxt_ta_left = bus_ff.ta & ~ta_last ? ta_left_ff - 2'h1 : ta_left_ff;
			nxt_act_rd = act_rd_ff;
		end
		// Write data comes from the master, so only reads turn drivers on
		nxt_bus.dq_oe = nxt_bus.ta & nxt_act_rd;
		nxt_gap = (ta_last & ~start_go) | fgn_done;

		nxt_pend = pend_ff;
		nxt_pend_rd = pend_rd_ff;
		nxt_pend_burst = pend_burst_ff;
		nxt_pend_ack = pend_ack_ff | aack_go;
		if (start_go)
		begin
			nxt_pend = 1'b0;
			nxt_pend_ack = 1'b0;
		end
		else if (claim_ok)
		begin
			nxt_pend = 1'b1;
			nxt_pend_rd = req.rd;
			nxt_pend_burst = req.burst;
			nxt_pend_ack = aack_go;
		end
		else if (pend_ff & foreign_rt)
		begin
			nxt_pend = 1'b0;
			nxt_pend_ack = 1'b0;
		end

		// Only one foreign tenure is tracked; deeper foreign pipelining is not followed
		nxt_fgn = fgn_ff;
		nxt_fgn_left = fgn_left_ff;
		nxt_fgn_fill = fgn_fill_ff;
		if (fgn_new)
		begin
			nxt_fgn = 1'b1;
			nxt_fgn_left = req.burst ? FGN_BURST : FGN_SINGLE;
			nxt_fgn_fill = fill_new;
		end
		else if (fgn_ff & foreign_rt)
		begin
			nxt_fgn = 1'b0;
		end
		else if (fgn_ff & ext_ta)
		begin
			nxt_fgn = ~fgn_done;
			nxt_fgn_left = fgn_left_ff - 3'h1;
		end
		// capture strobe for each memory beat of a foreign line fill
		nxt_evt.fill = fgn_ff & fgn_fill_ff & ext_ta;
		nxt_evt.inval = inval_new;

		nxt_rt = rt_ff;
		nxt_rt_cnt = rt_cnt_ff;
		nxt_bus.artry = 1'b0;
		unique case (rt_ff)
			RT_IDLE:
			begin
				if (retry_new)
				begin
					nxt_rt = RT_HOLD;
					nxt_rt_cnt = ARTRY_HOLD;
					nxt_bus.artry = 1'b1;
				end
			end
			RT_HOLD:
			begin
				nxt_bus.artry = rt_cnt_ff != 2'h0;
				nxt_rt_cnt = rt_cnt_ff - 2'h1;
				if (rt_cnt_ff == 2'h0)
				begin
					nxt_rt = RT_BRWIN;
				end
			end
			RT_BRWIN:
			begin
				// defer to the processor's own copy-back
				nxt_evt.defer = proc_bus_request;
				nxt_evt.copyback = ~proc_bus_request;
				nxt_rt = RT_IDLE;
			end
		endcase
		// drop request after a retry we did not drive
		nxt_bus.breq = nxt_evt.copyback | (bus_ff.breq & ~copyback_done & ~foreign_rt);

		// strap follows the pin only while reset is held
		nxt_fast = sys_rst ? streaming_fast_mode : fast_ff;
		nxt_en = (reg_wr & (reg_addr == REG_CTRL)) ? reg_wdata[CTRL_EN] : en_ff;
		stat = '{fast: fast_ff, rt_busy: rt_ff != RT_IDLE, fgn: fgn_ff, act: bus_ff.ta, pend: pend_ff, en: en_ff};
		nxt_rdata = 32'h0;
		if (reg_rd & (reg_addr == REG_CTRL))
		begin
			nxt_rdata[CTRL_EN] = en_ff;
		end
		else if (reg_rd & (reg_addr == REG_STAT))
		begin
			nxt_rdata[$bits(lcb_stat_t)-1:0] = stat;
		end
	end

	always_ff @(posedge core_clk)
	begin
		fast_ff <= nxt_fast;
		if (sys_rst)
		begin
			en_ff <= CTRL_EN_RST;
			pend_ff <= 1'b0;
			pend_rd_ff <= 1'b0;
			pend_burst_ff <= 1'b0;
			pend_ack_ff <= 1'b0;
			act_rd_ff <= 1'b0;
			gap_ff <= 1'b0;
			ta_left_ff <= 2'h0;
			fgn_ff <= 1'b0;
			fgn_left_ff <= 3'h0;
			fgn_fill_ff <= 1'b0;
			rt_ff <= RT_IDLE;
			rt_cnt_ff <= 2'h0;
			bus_ff <= '0;
			evt_ff <= '0;
			rdata_ff <= 32'h0;
		end
		else
		begin
			en_ff <= nxt_en;
			pend_ff <= nxt_pend;
			pend_rd_ff <= nxt_pend_rd;
			pend_burst_ff <= nxt_pend_burst;
			pend_ack_ff <= nxt_pend_ack;
			act_rd_ff <= nxt_act_rd;
			gap_ff <= nxt_gap;
			ta_left_ff <= nxt_ta_left;
			fgn_ff <= nxt_fgn;
			fgn_left_ff <= nxt_fgn_left;
			fgn_fill_ff <= nxt_fgn_fill;
			rt_ff <= nxt_rt;
			rt_cnt_ff <= nxt_rt_cnt;
			bus_ff <= nxt_bus;
			evt_ff <= nxt_evt;
			rdata_ff <= nxt_rdata;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_burst_beats;
		start_go && cur_burst |=> bus_o.ta [*4];
	endproperty
	a_burst_beats: assert property (p_burst_beats) else $error("burst not four beats");

	property p_single_beat;
		start_go && !cur_burst && !cur_rd |=> bus_o.ta ##1 !bus_o.ta;
	endproperty
	a_single_beat: assert property (p_single_beat) else $error("single beat length wrong");

	property p_quick;
		claim_ok && proc_data_grant && !bus_o.ta && !fgn_ff && !gap_ff && !artry_in
			|=> bus_o.ta && bus_o.aack && bus_o.claim;
	endproperty
	a_quick: assert property (p_quick) else $error("no next-cycle response");

	property p_gap;
		!fast_ff && bus_o.ta && ta_left_ff == 2'h0 |=> !bus_o.ta;
	endproperty
	a_gap: assert property (p_gap) else $error("missing turnaround");

	property p_stream;
		fast_ff && ta_last && act_rd_ff && pend_ff && pend_rd_ff && pend_ack_ff && !fgn_ff
			&& proc_data_grant && !artry_in |=> bus_o.ta && ta_left_ff != 2'h0 || bus_o.ta && !pend_burst_ff;
	endproperty
	a_stream: assert property (p_stream) else $error("read hits did not stream");

	property p_aack_last;
		last_next && cur_v && !cur_ack && !fgn_ff |=> bus_o.aack && bus_o.ta && ta_left_ff == 2'h0;
	endproperty
	a_aack_last: assert property (p_aack_last) else $error("aack not on last beat");

	property p_fgn_wait;
		bus_o.aack |-> !$past(fgn_ff);
	endproperty
	a_fgn_wait: assert property (p_fgn_wait) else $error("aack during foreign tenure");

	property p_wt_noclaim;
		ts && !req.rd && (req.wt || req.inh) |=> !bus_o.claim;
	endproperty
	a_wt_noclaim: assert property (p_wt_noclaim) else $error("write claimed wrongly");

	property p_inval;
		ts && en_ff && !req.snoop && req.rd && req.inh && req.hit && !req.dirty |=> evt_o.inval;
	endproperty
	a_inval: assert property (p_inval) else $error("clean line not invalidated");

	property p_retry;
		ts && en_ff && rt_ff == RT_IDLE && req.snoop && req.hit && req.dirty
			|=> bus_o.artry [*2] ##1 !bus_o.artry ##1 (evt_o.copyback || evt_o.defer);
	endproperty
	a_retry: assert property (p_retry) else $error("snoop retry sequence wrong");

	property p_defer;
		rt_ff == RT_BRWIN && proc_bus_request |=> evt_o.defer && !evt_o.copyback && !bus_o.breq;
	endproperty
	a_defer: assert property (p_defer) else $error("copy-back not deferred");

	property p_strap;
		!$past(sys_rst) |-> $stable(fast_ff);
	endproperty
	a_strap: assert property (p_strap) else $error("fast mode changed");

	c_stream: cover property (stream && start_go);
	c_fgn_aack: cover property (fgn_done ##[1:4] bus_o.aack);
	c_copyback: cover property (evt_o.copyback ##[1:20] copyback_done);
	c_fill: cover property (evt_o.fill [*4]);
endmodule // lcb_bus_slave

// ===== hdl/lcb_pkg.sv
// Constants and types for the look-aside cache bus slave
package lcb_pkg;
	localparam logic [1:0] BURST_LEFT = 2'h3;
	localparam logic [1:0] SINGLE_LEFT = 2'h0;
	localparam logic [1:0] LAST_BUT_ONE = 2'h1;
	localparam logic [2:0] FGN_BURST = 3'h4;
	localparam logic [2:0] FGN_SINGLE = 3'h1;
	localparam logic [1:0] ARTRY_HOLD = 2'h1;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam int CTRL_EN = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	typedef struct packed {
		logic snoop;
		logic rd;
		logic burst;
		logic inh;
		logic wt;
		logic hit;
		logic dirty;
	} lcb_req_t;
	typedef struct packed {
		logic claim;
		logic aack;
		logic ta;
		logic dq_oe;
		logic artry;
		logic breq;
	} lcb_bus_t;
	typedef struct packed {
		logic inval;
		logic copyback;
		logic fill;
		logic defer;
	} lcb_evt_t;
	typedef struct packed {
		logic fast;
		logic rt_busy;
		logic fgn;
		logic act;
		logic pend;
		logic en;
	} lcb_stat_t;
	typedef enum logic [1:0] {RT_IDLE, RT_HOLD, RT_BRWIN} lcb_rt_t;
endpackage

// ===== verification/lcb_far_model.sv
// Far-side model: parked data arbiter and foreign memory slave
`timescale 1ns/1ps
module lcb_far_model import lcb_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Bench control
	input wire logic park_en,
	input wire logic fgn_go,
	input wire logic [2:0] fgn_beats,
	// Bus side
	output logic proc_data_grant,
	output logic ext_ta
);
	logic wait_ff;
	logic [2:0] left_ff;
	// parked qualified grant
	// Held through the last beat, so a pipelined hit may stream
	assign proc_data_grant = park_en;
	always_ff @(posedge core_clk)
	begin
		ext_ta <= 1'b0;
		if (sys_rst)
		begin
			wait_ff <= 1'b0;
			left_ff <= 3'h0;
		end
		else if (fgn_go)
		begin
			wait_ff <= 1'b1;
			left_ff <= fgn_beats;
		end
		else if (wait_ff)
			wait_ff <= 1'b0;
		else if (left_ff != 3'h0)
		begin
			left_ff <= left_ff - 3'h1;
			ext_ta <= 1'b1;
		end
	end
endmodule // lcb_far_model

// ===== verification/lcb_bus_slave_tb.sv
// Self-checking bench for the cache bus slave
`timescale 1ns/1ps
module lcb_bus_slave_tb import lcb_pkg::*;;
	localparam lcb_req_t RD_HIT = 7'h32;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic fast = 1'b0;
	logic ts = 1'b0;
	lcb_req_t req = '0;
	logic pbr = 1'b0;
	logic cb_done = 1'b0;
	logic park = 1'b1;
	logic go = 1'b0;
	logic [2:0] nb = 3'h0;
	logic [3:0] ra = 4'h0;
	logic [31:0] rw = 32'h0;
	logic rwr = 1'b0;
	logic rrd = 1'b0;
	logic xrt = 1'b0;
	logic [3:0] xat = 4'h0;
	logic grant;
	logic ext_ta;
	lcb_bus_t bus;
	lcb_evt_t evt;
	logic [31:0] rdat;
	logic [15:0] tav;
	logic [15:0] aav;
	logic [15:0] flv;
	lcb_bus_t hb [16];
	lcb_evt_t he [16];
	int fails = 0;
	int checks_done = 0;
	// Row: request, claim, retry, invalidate, foreign beats
	logic [12:0] rows [8] = '{13'h0ca0, 13'h0a89, 13'h0ed0, 13'h04a0, 13'h0584, 13'h0190, 13'h0290, 13'h00a0};
	always #10 core_clk = ~core_clk;
	// Wired retry: this slave or an injected foreign retry
	lcb_bus_slave i_lcb_bus_slave (.core_clk(core_clk), .sys_rst(sys_rst), .streaming_fast_mode(fast), .ts(ts),
		.req(req), .proc_data_grant(grant), .proc_bus_request(pbr), .artry_in(bus.artry | xrt), .ext_ta(ext_ta),
		.copyback_done(cb_done), .bus_o(bus), .evt_o(evt), .reg_addr(ra), .reg_wdata(rw), .reg_wr(rwr),
		.reg_rd(rrd), .reg_rdata(rdat));
	lcb_far_model i_lcb_far_model (.core_clk(core_clk), .sys_rst(sys_rst), .park_en(park), .fgn_go(go),
		.fgn_beats(nb), .proc_data_grant(grant), .ext_ta(ext_ta));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic do_reset(input logic f);
		@(posedge core_clk);
		fast <= f;
		sys_rst <= 1'b1;
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		rrd <= 1'b1;
		ra <= a;
		@(posedge core_clk);
		rrd <= 1'b0;
		#1 d = rdat;
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		rwr <= 1'b1;
		ra <= a;
		rw <= d;
		@(posedge core_clk);
		rwr <= 1'b0;
	endtask
	// Second request, if any, starts in cycle at
	task automatic run(input lcb_req_t r1, input logic [2:0] n, input lcb_req_t r2, input int at);
		tav = '0;
		aav = '0;
		flv = '0;
		@(posedge core_clk);
		ts <= 1'b1;
		req <= r1;
		go <= (n != 3'h0);
		nb <= n;
		for (int i = 1; i < 16; i++)
		begin
			@(posedge core_clk);
			ts <= (i == at);
			req <= r2;
			go <= 1'b0;
			park <= 1'b1;
			xrt <= (i == xat);
			#1;
			hb[i] = bus;
			he[i] = evt;
			tav[i] = bus.ta;
			aav[i] = bus.aack;
			flv[i] = evt.fill;
		end
		@(posedge core_clk);
		cb_done <= 1'b1;
		@(posedge core_clk);
		cb_done <= 1'b0;
	endtask
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fails++;
		summarize();
	end
	initial
	begin
		logic [31:0] d;
		do_reset(1'b0);
		reg_rd(REG_CTRL, d);
		chk("ctrl_reset", 32'h1, d);
		reg_rd(4'hc, d);
		chk("unmapped", 32'h0, d);
		foreach (rows[k])
		begin
			run(lcb_req_t'(rows[k][12:6]), rows[k][2:0], '0, 0);
			chk("claim", 32'(rows[k][5]), 32'(hb[1].claim));
			chk("ta_first", 32'(rows[k][5]), 32'(hb[1].ta));
			chk("ta_beats", rows[k][5] ? (rows[k][10] ? 32'h4 : 32'h1) : 32'h0, 32'($countones(tav)));
			chk("dq_oe", 32'(rows[k][5] & rows[k][11]), 32'(hb[1].dq_oe));
			chk("retry", 32'(rows[k][4]), 32'(hb[1].artry));
			chk("inval", 32'(rows[k][3]), 32'(he[1].inval));
		end
		@(posedge core_clk);
		park <= 1'b0;
		run(RD_HIT, 3'h0, '0, 0);
		chk("ta_nogrant", 32'h0, 32'(hb[1].ta));
		chk("ta_late", 32'h4, 32'($countones(tav)));
		reg_wr(REG_CTRL, 32'h0);
		run(RD_HIT, 3'h4, '0, 0);
		chk("claim_off", 32'h0, 32'(hb[1].claim));
		reg_wr(REG_CTRL, 32'h1);
		for (int p = 0; p < 2; p++)
		begin
			pbr <= p[0];
			run(7'h43, 3'h0, '0, 0);
			chk("artry", 32'h3, 32'({hb[3].artry, hb[2].artry, hb[1].artry}));
			chk("copyback", 32'(!p[0]), 32'(he[4].copyback));
			chk("breq", 32'(!p[0]), 32'(hb[4].breq));
			chk("defer", 32'(p[0]), 32'(he[4].defer));
		end
		pbr <= 1'b0;
		xat <= 4'h6;
		run(7'h43, 3'h0, '0, 0);
		chk("breq_hold", 32'h1, 32'(hb[6].breq));
		chk("breq_drop", 32'h0, 32'(hb[7].breq));
		xat <= 4'h0;
		run(7'h30, 3'h4, RD_HIT, 3);
		chk("fill", 32'h00f0, 32'(flv));
		chk("ta_fgn", 32'h0f00, 32'(tav));
		chk("aack_wait", 32'h0, 32'(aav[6:0]));
		chk("aack_late", 32'h1, 32'(|aav[15:7]));
		for (int f = 1; f >= 0; f--)
		begin
			do_reset(f[0]);
			reg_rd(REG_STAT, d);
			chk("stat_fast", 32'(f[0]), 32'(d[5]));
			run(RD_HIT, 3'h0, RD_HIT, 3);
			chk("ta_stream", f[0] ? 32'h01fe : 32'h03de, 32'(tav));
			chk("aack_pipe", 32'h0012, 32'(aav));
		end
		summarize();
	end
endmodule // lcb_bus_slave_tb
